// ==== rtl/adc_host.v ====
// Host controller that drives the DRAM card strobes, address and data pins
`timescale 1ns/10ps
`include "adc_defs.vh"
module adc_host #(
  parameter REFI_CYC = `ADC_REFI_CYC,  // Distributed COL_BEFORE_ROW_REFRESH spacing, per row
  parameter RASS_CYC = `ADC_RASS_CYC,  // Self-refresh entry row-low time
  parameter DW       = `ADC_DATA_BITS
) (
  input  wire          clk,
  input  wire          reset,
  // User request port
  input  wire          req_valid,      // Access request
  output wire          req_ready,      // Request taken this cycle
  input  wire          req_write,      // 1 write, 0 read
  input  wire [19:0]   req_addr,       // Row in [19:10], column in [9:0]
  input  wire [3:0]    req_be,         // Byte lanes
  input  wire [DW-1:0] req_wdata,      // Write data
  input  wire          req_page,       // Keep row open for a following access
  output reg           rsp_valid,      // One-cycle pulse with read data
  output reg  [DW-1:0] rsp_rdata,      // Read data
  input  wire          self_ref_req,   // Level: hold card in self refresh
  output reg           self_ref_act,   // Card is in self refresh
  // Card pins
  output reg           row_strobe_n,
  output reg  [3:0]    col_strobe_n,
  output reg           wr_en_n,
  output reg  [9:0]    mux_addr,
  input  wire [DW-1:0] data_io_i,
  output reg  [DW-1:0] data_io_o,
  output reg           data_io_oe_n
);
  localparam [3:0] S_IDLE = 4'h0, S_RAS = 4'h1, S_CAS = 4'h2, S_CASH = 4'h3,
                   S_PRE = 4'h4, S_CBR_C = 4'h5, S_CBR_R = 4'h6, S_SELF = 4'h7,
                   S_SELF_X = 4'h8, S_BURST = 4'h9, S_PAGE = 4'ha;
  localparam integer C_RCD = `ADC_CYC_UP(`ADC_T_RCD_NS);
  localparam integer C_SYN = 3;  // Pin synchroniser chain depth on read data
  // Column low spans access time, the three-flop chain and its agree step
  localparam integer C_CAS = `ADC_CYC_UP(`ADC_T_CAS_NS) + C_SYN + 2;
  localparam integer C_CP  = `ADC_CYC_UP(`ADC_T_CP_NS);
  localparam integer C_RP  = `ADC_CYC_UP(`ADC_T_RP_NS);
  localparam integer C_RAS = `ADC_CYC_UP(`ADC_T_RAS_NS);
  localparam integer C_CSR = `ADC_CYC_UP(`ADC_T_CSR_NS);
  localparam integer C_RPS = `ADC_CYC_UP(`ADC_T_RPS_NS);
  localparam [10:0]  C_ROWS = `ADC_ROWS;  // Rows in a post-exit burst

  // Saturating-free width helper for counter loads
  function [23:0] cnt24;
    input integer v;
    begin
      cnt24 = v[23:0];
    end
  endfunction

  reg  [3:0]    st_q;        // Controller state
  reg  [23:0]   tmr_q;       // Phase timer
  reg  [23:0]   refi_q;      // Refresh interval counter
  reg           ref_due_q;   // A distributed refresh is owed
  reg  [10:0]   burst_q;     // Rows left in post-exit burst
  reg  [9:0]    open_row_q;  // Row held open in page mode
  reg           wr_q;        // Current access is a write
  reg           page_q;      // Row to stay open after this access
  wire [DW-1:0] rd_sync;     // Synchronised data pins
  reg  [9:0]    hcol_q;      // Column of the request taken at idle
  reg           hwr_q;       // Its write flag
  reg  [3:0]    hbe_q;       // Its byte lanes
  reg  [DW-1:0] hwdata_q;    // Its write data
  reg           hpage_q;     // Its page flag
  reg  [3:0]    req_be_q;    // Lanes of the access being issued
  reg  [7:0]    ras_cnt_q;   // Row low time, saturating
  // Fields only stand until taken, so a row open uses the held copy; a page hit is live
  wire          from_hold  = (st_q == S_RAS);
  wire [9:0]    col_w      = from_hold ? hcol_q : req_addr[9:0];
  wire          wr_w       = from_hold ? hwr_q : req_write;
  wire [3:0]    be_w       = from_hold ? hbe_q : req_be;
  wire [DW-1:0] wdata_w    = from_hold ? hwdata_q : req_wdata;
  wire          page_w     = from_hold ? hpage_q : req_page;
  // Page may only continue while the row has not been low too long
  wire          tmr_ras_ok = (ras_cnt_q != 8'hff);

  adc_sync #(.W(DW)) u_sync (
    .clk   (clk),
    .reset (reset),
    .din   (data_io_i),
    .dout  (rd_sync)
  );

  wire tmr_done = (tmr_q == 24'h000000);
  // Take a request at idle, or in page state when it hits the open row
  // Refused while a post-exit burst is pending, since idle would start a refresh
  assign req_ready = req_valid && !ref_due_q && !self_ref_req && (burst_q == 11'h000) &&
                     ((st_q == S_IDLE) ||
                      (st_q == S_PAGE && tmr_ras_ok &&
                       req_addr[19:10] == open_row_q));

  // Refresh interval: one COL_BEFORE_ROW_REFRESH per row slice so all rows meet the period
  always @(posedge clk) begin
    if (reset) begin
      refi_q    <= 24'h000000;
      ref_due_q <= 1'b0;
    end else begin
      if (refi_q >= cnt24(REFI_CYC) - 24'h000001) begin
        refi_q    <= 24'h000000;
        ref_due_q <= 1'b1;                                // Set wins over clear
      end else begin
        refi_q <= refi_q + 24'h000001;
        if (st_q == S_CBR_R && tmr_done)
          ref_due_q <= 1'b0;
      end
    end
  end

  // Main sequencer
  always @(posedge clk) begin
    if (reset) begin
      st_q         <= S_IDLE;
      tmr_q        <= 24'h000000;
      burst_q      <= 11'h000;
      open_row_q   <= 10'h000;
      wr_q         <= 1'b0;
      page_q       <= 1'b0;
      hcol_q       <= 10'h000;
      hwr_q        <= 1'b0;
      hbe_q        <= 4'h0;
      hwdata_q     <= {DW{1'b0}};
      hpage_q      <= 1'b0;
      rsp_valid    <= 1'b0;
      rsp_rdata    <= {DW{1'b0}};
      self_ref_act <= 1'b0;
      row_strobe_n <= 1'b1;
      col_strobe_n <= 4'hf;
      wr_en_n      <= 1'b1;
      mux_addr     <= 10'h000;
      data_io_o    <= {DW{1'b0}};
      data_io_oe_n <= 1'b1;
    end else begin
      rsp_valid <= 1'b0;
      if (!tmr_done)
        tmr_q <= tmr_q - 24'h000001;
      case (st_q)
        S_IDLE: begin
          // Both strobes high: standby with the bus released
          row_strobe_n <= 1'b1;
          col_strobe_n <= 4'hf;
          data_io_oe_n <= 1'b1;
          wr_en_n      <= 1'b1;
          if (ref_due_q || self_ref_req || burst_q != 11'h000) begin
            // COL_BEFORE_ROW_REFRESH: column strobes low first, write enable high
            col_strobe_n <= 4'h0;
            tmr_q        <= cnt24(C_CSR - 1);
            st_q         <= S_CBR_C;
          end else if (req_ready) begin
            mux_addr     <= req_addr[19:10];
            open_row_q   <= req_addr[19:10];
            // Keep the rest of the request for the column phase
            hcol_q       <= req_addr[9:0];
            hwr_q        <= req_write;
            hbe_q        <= req_be;
            hwdata_q     <= req_wdata;
            hpage_q      <= req_page;
            row_strobe_n <= 1'b0;
            tmr_q        <= cnt24(C_RCD - 1);
            st_q         <= S_RAS;
          end
        end
        S_RAS, S_PAGE: begin
          if (st_q == S_PAGE && ((!req_page && !req_valid) || !tmr_ras_ok)) begin
            // Page closed or row low too long: row strobe high ends the page
            row_strobe_n <= 1'b1;
            tmr_q        <= cnt24(C_RP - 1);
            st_q         <= S_PRE;
          end else if (st_q == S_PAGE && !req_ready) begin
            if (req_valid || ref_due_q || self_ref_req) begin
              row_strobe_n <= 1'b1;                        // Row miss or refresh
              tmr_q        <= cnt24(C_RP - 1);
              st_q         <= S_PRE;
            end
          end else if (tmr_done) begin
            // Column phase: write enable and data settle before the strobe
            mux_addr     <= col_w;
            wr_q         <= wr_w;
            page_q       <= page_w;
            wr_en_n      <= ~wr_w;
            data_io_o    <= wdata_w;
            data_io_oe_n <= ~wr_w;
            tmr_q        <= cnt24(C_CAS - 1);
            st_q         <= S_CAS;
          end
        end
        S_CAS: begin
          // Strobe falls a cycle after address, write enable and data
          col_strobe_n <= ~req_be_q;
          if (tmr_done) begin
            if (!wr_q) begin
              rsp_rdata <= rd_sync;
              rsp_valid <= 1'b1;
            end
            col_strobe_n <= 4'hf;
            data_io_oe_n <= 1'b1;
            tmr_q        <= cnt24(C_CP - 1);
            st_q         <= S_CASH;
          end
        end
        S_CASH: begin
          if (tmr_done) begin
            wr_en_n <= 1'b1;
            if (page_q && tmr_ras_ok) begin
              st_q <= S_PAGE;
            end else begin
              row_strobe_n <= 1'b1;
              tmr_q        <= cnt24(C_RP - 1);
              st_q         <= S_PRE;
            end
          end
        end
        S_PRE: begin
          col_strobe_n <= 4'hf;
          if (tmr_done)
            st_q <= S_IDLE;
        end
        S_CBR_C: begin
          if (tmr_done) begin
            row_strobe_n <= 1'b0;
            tmr_q        <= self_ref_req ? cnt24(RASS_CYC - 1) : cnt24(C_RAS - 1);
            st_q         <= self_ref_req ? S_SELF : S_CBR_R;
          end
        end
        S_CBR_R: begin
          if (tmr_done) begin
            row_strobe_n <= 1'b1;
            col_strobe_n <= 4'hf;
            if (burst_q != 11'h000)
              burst_q <= burst_q - 11'h001;
            tmr_q <= cnt24(C_RP - 1);
            st_q  <= S_PRE;
          end
        end
        S_SELF: begin
          // Row held low past the entry time: card refreshes itself
          if (tmr_done)
            self_ref_act <= 1'b1;
          if (!self_ref_req && tmr_done) begin
            row_strobe_n <= 1'b1;
            col_strobe_n <= 4'hf;
            tmr_q        <= cnt24(C_RPS - 1);
            st_q         <= S_SELF_X;
          end
        end
        S_SELF_X: begin
          if (tmr_done) begin
            self_ref_act <= 1'b0;
            burst_q      <= C_ROWS;
            st_q         <= S_IDLE;
          end
        end
        default: st_q <= S_IDLE;
      endcase
    end
  end

  // Byte lanes of the access being issued, held through the column phase
  always @(posedge clk) begin
    if (reset)
      req_be_q <= 4'h0;
    else if (st_q == S_RAS || st_q == S_PAGE)
      req_be_q <= wr_w ? be_w : 4'hf;
  end

  // Row low time guard for page continuation
  always @(posedge clk) begin
    if (reset || row_strobe_n)
      ras_cnt_q <= 8'h00;
    else if (ras_cnt_q != 8'hff)
      ras_cnt_q <= ras_cnt_q + 8'h01;
  end
endmodule // adc_host

// ==== rtl/adc_defs.vh ====
// Constants and timing figures for the DRAM card host controller
`ifndef ADC_DEFS_VH
`define ADC_DEFS_VH
`define ADC_CLK_MHZ        20
`define ADC_ROW_BITS       10
`define ADC_COL_BITS       10
`define ADC_DATA_BITS      32
`define ADC_LANES          4
`define ADC_ROWS           1024
// Times in ns, except where the name says otherwise
`define ADC_T_RC_NS        130
`define ADC_T_RP_NS        50
`define ADC_T_RAS_NS       70
`define ADC_T_RCD_NS       20
`define ADC_T_CAS_NS       20
`define ADC_T_CP_NS        10
`define ADC_T_CSR_NS       10
`define ADC_T_CHR_NS       10
`define ADC_T_RPS_NS       130
`define ADC_T_RASS_US      100
`define ADC_T_REF_MS       128
`define ADC_T_BURST_US     300
`define ADC_T_DIST_US      125
// Least times round up, at least one cycle
`define ADC_CYC_UP(ns)     (((ns) * `ADC_CLK_MHZ + 999) / 1000 < 1 ? 1 : \
                            ((ns) * `ADC_CLK_MHZ + 999) / 1000)
// Longest time (refresh spacing) rounds down
`define ADC_REFI_CYC       ((`ADC_T_REF_MS * 1000 * `ADC_CLK_MHZ) / `ADC_ROWS)
`define ADC_RASS_CYC       (`ADC_T_RASS_US * `ADC_CLK_MHZ)
`define ADC_DIST_CYC       (`ADC_T_DIST_US * `ADC_CLK_MHZ)
`endif

// ==== rtl/adc_sync.v ====
// Three-stage input synchroniser for card pins
`timescale 1ns/10ps
module adc_sync #(
  parameter W = 32
) (
  input  wire         clk,
  input  wire         reset,
  input  wire [W-1:0] din,
  output reg  [W-1:0] dout
);
  reg [W-1:0] s1_q;  // First stage, read only by the second
  reg [W-1:0] s2_q;  // Second stage
  reg [W-1:0] s3_q;  // Third stage
  // Shift chain; output updates only when stages two and three agree per bit
  always @(posedge clk) begin
    if (reset) begin
      s1_q <= {W{1'b0}};
      s2_q <= {W{1'b0}};
      s3_q <= {W{1'b0}};
      dout <= {W{1'b0}};
    end else begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
      dout <= (s2_q & s3_q) | (~(s2_q ^ s3_q) & s3_q) | ((s2_q ^ s3_q) & dout);
    end
  end
endmodule // adc_sync

// ==== testbench/adc_host_monitor.sv ====
// Checker bound to the DRAM card host controller
`timescale 1ns/10ps
module adc_host_monitor #(
  parameter REFI_CYC = 2500,
  parameter RASS_CYC = 2000
) (
  input wire       clk,
  input wire       reset,
  input wire       self_ref_req,
  input wire       self_ref_act,
  input wire       row_strobe_n,
  input wire [3:0] col_strobe_n,
  input wire       wr_en_n,
  input wire       data_io_oe_n
);
  reg        row_p_q;  // Row strobe one cycle back
  reg        colh_p_q; // All column strobes high one cycle back
  reg [15:0] low_q;    // Length of a refresh row-low phase
  reg [15:0] gap_q;    // Cycles since the last refresh
  wire       col_hi = col_strobe_n == 4'hf;
  wire       col_fall = !row_strobe_n && colh_p_q && !col_hi;
  // Helper counters; a refresh phase starts only with the columns already low
  always @(posedge clk) begin
    if (reset) begin
      row_p_q <= 1'b1;
      colh_p_q <= 1'b1;
      low_q <= 16'h0;
      gap_q <= 16'h0;
    end else begin
      row_p_q <= row_strobe_n;
      colh_p_q <= col_hi;
      low_q <= (!row_strobe_n && (low_q != 16'h0 || (row_p_q && col_strobe_n == 4'h0)))
               ? low_q + 16'h1 : 16'h0;
      gap_q <= (self_ref_req || self_ref_act || low_q != 16'h0) ? 16'h0 : gap_q + 16'h1;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  property p_we_early; col_fall |-> $stable(wr_en_n); endproperty
  a_we_early: assert property (p_we_early) else $error("write enable moved at column fall");
  property p_wr_drive; col_fall && !wr_en_n |-> !data_io_oe_n; endproperty
  a_wr_drive: assert property (p_wr_drive) else $error("write data not driven");
  property p_rd_free; col_fall && wr_en_n |-> data_io_oe_n; endproperty
  a_rd_free: assert property (p_rd_free) else $error("bus driven in a read");
  property p_cbr; $fell(row_strobe_n) && col_strobe_n == 4'h0 |-> wr_en_n && data_io_oe_n; endproperty
  a_cbr: assert property (p_cbr) else $error("refresh with write low or bus driven");
  property p_standby; $rose(row_strobe_n) && col_hi |=> data_io_oe_n; endproperty
  a_standby: assert property (p_standby) else $error("bus held in standby");
  property p_close; $rose(row_strobe_n) && low_q == 16'h0 |-> col_hi; endproperty
  a_close: assert property (p_close) else $error("row closed with column low");
  property p_entry; $rose(row_strobe_n) && low_q > 16'h8 |-> low_q >= RASS_CYC - 1; endproperty
  a_entry: assert property (p_entry) else $error("self refresh row low too short");
  property p_exit; $rose(row_strobe_n) && low_q > 16'h8 |-> row_strobe_n [*3]; endproperty
  a_exit: assert property (p_exit) else $error("exit precharge too short");
  property p_refi; !self_ref_req && !self_ref_act |-> gap_q < REFI_CYC + 64; endproperty
  a_refi: assert property (p_refi) else $error("refresh spacing exceeded");
  c_cbr: cover property ($fell(row_strobe_n) && col_strobe_n == 4'h0);
  c_self: cover property ($rose(row_strobe_n) && low_q > 16'h8);
  c_write: cover property (col_fall && !wr_en_n);
endmodule // adc_host_monitor
bind adc_host adc_host_monitor #(.REFI_CYC(REFI_CYC), .RASS_CYC(RASS_CYC)) u_mon (
  .clk(clk), .reset(reset), .self_ref_req(self_ref_req), .self_ref_act(self_ref_act),
  .row_strobe_n(row_strobe_n), .col_strobe_n(col_strobe_n), .wr_en_n(wr_en_n),
  .data_io_oe_n(data_io_oe_n));

// ==== testbench/adc_card_model.sv ====
// Behavioural model of the DRAM card on the controller's pins
`timescale 1ns/10ps
module adc_card_model (
  input  wire        row_strobe_n,
  input  wire [3:0]  col_strobe_n,
  input  wire        wr_en_n,
  input  wire [9:0]  mux_addr,
  input  wire [31:0] data_io_o,
  input  wire        data_io_oe_n,
  output reg  [31:0] data_io_i,
  output integer     cbr_count,
  output integer     act_count
);
  bit [31:0] mem [int];          // Sparse storage, row and column
  reg [9:0]  row_q = 10'h0;      // Open row
  reg [9:0]  ref_row_q = 10'h0;  // Internal refresh row counter
  reg [3:0]  col_p_q = 4'hf;     // Column strobes before this change
  reg [3:0]  drv_q = 4'h0;       // Lanes the card drives
  reg [31:0] rd_q = 32'h0;       // Read data, also the source of released levels
  int        a;
  initial begin
    cbr_count = 0;
    act_count = 0;
  end
  // Row fall: refresh if columns already low, else open a row
  always @(negedge row_strobe_n) begin
    if (col_strobe_n == 4'h0 && wr_en_n) begin
      ref_row_q <= ref_row_q + 10'h1;
      cbr_count <= cbr_count + 1;
    end else begin
      row_q <= mux_addr;
      act_count <= act_count + 1;
    end
  end
  // Column edges per lane; read lanes stay driven while their strobe is low
  always @(col_strobe_n) begin
    a = {row_q, mux_addr};
    for (int l = 0; l < 4; l++) begin
      if (col_p_q[l] && !col_strobe_n[l] && !row_strobe_n) begin
        if (!wr_en_n)
          mem[a][8*l+:8] = data_io_i[8*l+:8];
        else begin
          rd_q[8*l+:8] = mem[a][8*l+:8];
          drv_q[l] = 1'b1;
        end
      end
      if (col_strobe_n[l])
        drv_q[l] = 1'b0;
    end
    col_p_q = col_strobe_n;
  end
  // Bus level; a released lane shows the inverse so stale data never passes
  always @* begin
    for (int l = 0; l < 4; l++)
      data_io_i[8*l+:8] = !data_io_oe_n ? data_io_o[8*l+:8] :
                          drv_q[l] ? rd_q[8*l+:8] : ~rd_q[8*l+:8];
  end
endmodule // adc_card_model

// ==== testbench/adc_host_tb.sv ====
// Self-checking bench for the DRAM card host controller
`timescale 1ns/10ps
module adc_host_tb;
  reg         clk = 1'b0;
  reg         reset = 1'b1;
  reg         req_valid = 1'b0, req_write = 1'b0, req_page = 1'b0, self_ref_req = 1'b0;
  reg  [19:0] req_addr = 20'h0;
  reg  [3:0]  req_be = 4'hf;
  reg  [31:0] req_wdata = 32'h0;
  wire        req_ready, rsp_valid, self_ref_act, row_strobe_n, wr_en_n, data_io_oe_n;
  wire [31:0] rsp_rdata, data_io_i, data_io_o;
  wire [3:0]  col_strobe_n;
  wire [9:0]  mux_addr;
  integer     cbr_count, act_count, err_count = 0, num_checks = 0, cyc = 0, base, n;
  reg  [31:0] q;
  always #25 clk = ~clk;
  // Short refresh spacing keeps the run brief
  adc_host #(.REFI_CYC(400), .RASS_CYC(20)) u_dut (.clk(clk), .reset(reset),
    .req_valid(req_valid), .req_ready(req_ready), .req_write(req_write),
    .req_addr(req_addr), .req_be(req_be), .req_wdata(req_wdata), .req_page(req_page),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .self_ref_req(self_ref_req),
    .self_ref_act(self_ref_act), .row_strobe_n(row_strobe_n), .col_strobe_n(col_strobe_n),
    .wr_en_n(wr_en_n), .mux_addr(mux_addr), .data_io_i(data_io_i), .data_io_o(data_io_o),
    .data_io_oe_n(data_io_oe_n));
  adc_card_model u_card (.row_strobe_n(row_strobe_n), .col_strobe_n(col_strobe_n),
    .wr_en_n(wr_en_n), .mux_addr(mux_addr), .data_io_o(data_io_o),
    .data_io_oe_n(data_io_oe_n), .data_io_i(data_io_i), .cbr_count(cbr_count),
    .act_count(act_count));
  task give_verdict;
    begin
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      num_checks = num_checks + 1;
      if (got !== exp) begin
        err_count = err_count + 1;
        $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  // Cycle ceiling cuts a hang short
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 60000) begin
      err_count = err_count + 1;
      give_verdict;
    end
  end
  // One request held until taken; reads wait for the answer pulse
  task acc(input w, input [19:0] a, input [3:0] be, input [31:0] d, input pg);
    begin
      @(posedge clk);
      #1;
      {req_valid, req_write, req_addr, req_be, req_wdata, req_page} = {1'b1, w, a, be, d, pg};
      #1;  // Let the combinational ready settle before it is looked at
      for (n = 0; !req_ready && n < 8000; n = n + 1) begin
        @(posedge clk);
        #1;
      end
      @(posedge clk);
      #1;
      req_valid = 1'b0;
      for (n = 0; !w && !rsp_valid && n < 50; n = n + 1) begin
        @(posedge clk);
        #1;
      end
      q = rsp_rdata;
    end
  endtask
  // Row 0 column 0x155 and row 0x55 column 0 must reach distinct words; partial lanes
  task t_addr;
    begin
      acc(1, 20'h00155, 4'hf, 32'h0a0b0c0d, 0);
      acc(1, 20'h15400, 4'hf, 32'h11223344, 0);
      acc(1, 20'h15400, 4'h5, 32'haabbccdd, 0);
      acc(0, 20'h00155, 4'hf, 0, 0);
      chk(q, 32'h0a0b0c0d);
      acc(0, 20'h15400, 4'hf, 0, 0);
      chk(q, 32'h11bb33dd);
    end
  endtask
  // Page hits open the row once; closing forces a new row cycle
  task t_page;
    begin
      base = cbr_count;
      wait (cbr_count != base);
      base = act_count;
      acc(1, 20'h2a801, 4'hf, 32'h5555aaaa, 1);
      acc(1, 20'h2a802, 4'hf, 32'h0f0f0f0f, 1);
      acc(0, 20'h2a801, 4'hf, 0, 0);
      chk(q, 32'h5555aaaa);
      chk(act_count - base, 1);
      acc(0, 20'h2a802, 4'hf, 0, 0);
      chk(q, 32'h0f0f0f0f);
      chk(act_count - base, 2);
    end
  endtask
  // Idle refresh rate, then self refresh entry, silence, exit and burst
  task t_refresh;
    begin
      base = cbr_count;
      repeat (1200) @(posedge clk);
      chk((cbr_count - base) >= 2 && (cbr_count - base) <= 4, 1);
      #1;
      self_ref_req = 1'b1;
      for (n = 0; !self_ref_act && n < 3000; n = n + 1) @(posedge clk);
      repeat (2) @(posedge clk);
      base = cbr_count;
      repeat (200) @(posedge clk);
      #1;
      chk(cbr_count - base, 0);
      chk(row_strobe_n, 0);
      chk(self_ref_act, 1);
      self_ref_req = 1'b0;
      acc(0, 20'h00155, 4'hf, 0, 0);
      chk(q, 32'h0a0b0c0d);
      chk(cbr_count - base >= 1024, 1);
    end
  endtask
  initial begin
    repeat (20) @(posedge clk);
    #1;
    reset = 1'b0;
    t_addr;
    t_page;
    t_refresh;
    give_verdict;
  end
endmodule // adc_host_tb
